// File: rtl/alt_toggle_timer.v
// Purpose: toggle a phase bit at a fixed period while enabled
// Assumes: period fits in 30 bits
// Notes:   phase returns to the first half when disabled
//          the count is cut to 30 bits on purpose
`timescale 1ns/100ps

module alt_toggle_timer #(
    parameter integer PERIOD_CYCLES = 625000000
) (
    // clock and reset
    input  wire i_core_clk,
    input  wire i_sys_rst,
    // control
    input  wire i_enable,
    // phase output
    output reg  o_phase
);

    localparam [29:0] LAST = PERIOD_CYCLES[29:0] - 30'h1;

    reg [29:0] count;

    // count while enabled, restart on enable
    always @(posedge i_core_clk) begin
        if (i_sys_rst || !i_enable) begin
            count   <= 30'h0;
            o_phase <= 1'b0;
        end else if (count == LAST) begin
            count   <= 30'h0;
            o_phase <= ~o_phase;
        end else begin
            count <= count + 30'h1;
        end
    end

endmodule // alt_toggle_timer

// File: rtl/crc16_byte_step.v
// Purpose: advance a reflected CRC-16 by one byte
// Assumes: lsb-first polynomial form
// Notes:   combinational, used on receive and send paths
`timescale 1ns/100ps

module crc16_byte_step #(
    parameter [15:0] POLY = 16'ha001
) (
    // crc state and byte
    input  wire [15:0] i_crc,
    input  wire [7:0]  i_byte,
    // next state
    output reg  [15:0] o_crc
);

    integer k;

    // eight shift steps, unrolled by the tool
    always @* begin
        o_crc = i_crc ^ {8'h00, i_byte};
        for (k = 0; k < 8; k = k + 1) begin
            if (o_crc[0]) begin
                o_crc = (o_crc >> 1) ^ POLY;
            end else begin
                o_crc = o_crc >> 1;
            end
        end
    end

endmodule // crc16_byte_step

// File: rtl/sensor_config_defines.vh
// Purpose: constants shared by the sensor configuration holding registers
// Assumes: write-single-register frames, 16-bit register values
// Notes:   definitions only, no logic
`ifndef SENSOR_CONFIG_DEFINES_VH
`define SENSOR_CONFIG_DEFINES_VH

// ============================================================
// frame layout
`define FC_WRITE_SINGLE     8'h06
`define FC_EXCEPTION_FLAG   8'h80
`define WRITE_FRAME_BYTES   4'h8
`define EXC_FRAME_BYTES     4'h5
`define MIN_FRAME_BYTES     4'h4
`define CRC_SEED            16'hffff
`define CRC_POLY            16'ha001

// ============================================================
// exception codes
`define EXC_ILLEGAL_FUNC    8'h01
`define EXC_ILLEGAL_ADDR    8'h02
`define EXC_ILLEGAL_DATA    8'h03

// ============================================================
// register addresses
`define ADDR_UPPER_LIMIT    16'h0009
`define ADDR_LCD_CONTENT    16'h000a
`define ADDR_TEMP_SCALE     16'h000b
`define ADDR_LCD_STEP       16'h000c
`define ADDR_OCCUPIED       16'h000d
`define ADDR_OVR_CLEAR      16'h000e
`define ADDR_RELAY          16'h000f
`define ADDR_TARGET_QTY     16'h0010
`define ADDR_TARGET_STEP    16'h0011

// ============================================================
// value ranges (tenths of a degree, whole percent RH)
`define LIMIT_C_LO          16'h00c8
`define LIMIT_C_HI          16'h012c
`define LIMIT_F_LO          16'h02a8
`define LIMIT_F_HI          16'h035c
`define LIMIT_RH_LO         16'h001e
`define LIMIT_RH_HI         16'h0050
`define LCD_MODE_MAX_T      16'h0001
`define LCD_MODE_MAX_TRH    16'h0003
`define FLAG_VALUE_MAX      16'h0001

// ============================================================
// display modes
`define LCD_BLANK           2'h0
`define LCD_TEMP            2'h1
`define LCD_HUMID           2'h2
`define LCD_ALTERNATE       2'h3

// ============================================================
// reset values
`define RST_UPPER_LIMIT     16'h012c
`define RST_LCD_T_ONLY      2'h1
`define RST_LCD_T_RH        2'h3

// ============================================================
// timing
`define ALT_PERIOD_MS       5000
`define CLK_FREQ_KHZ        125000

`endif

// File: rtl/sensor_config_holding_regs.v
// Purpose: upper holding-register bank of a room sensor, written by a
//          field-bus master with write-single-register frames
// Assumes: bytes arrive already deframed; i_rx_frame_end marks the
//          silent gap after the last byte; half duplex
// Notes:   fitted options are module parameters
`timescale 1ns/100ps
`include "sensor_config_defines.vh"

module sensor_config_holding_regs #(
    parameter HAS_HUMIDITY = 1,
    parameter HAS_SETPOINT = 1,
    parameter HAS_OVERRIDE = 1,
    parameter HAS_RELAY    = 1,
    parameter integer ALT_PERIOD_CYCLES =
        `ALT_PERIOD_MS * `CLK_FREQ_KHZ
) (
    // clock and reset
    input  wire        i_core_clk,
    input  wire        i_sys_rst,
    // station address
    input  wire [7:0]  i_slave_addr,
    // received bytes
    input  wire [7:0]  i_rx_byte,
    input  wire        i_rx_valid,
    input  wire        i_rx_frame_end,
    // reply bytes
    output reg  [7:0]  o_tx_byte,
    output wire        o_tx_valid,
    input  wire        i_tx_ready,
    // front panel
    input  wire        i_override_pressed,
    input  wire        i_menu_active,
    input  wire [15:0] i_target_value,
    // display
    output wire        o_lcd_show_temp,
    output wire        o_lcd_show_humidity,
    output wire        o_backlight_on,
    output wire        o_lcd_half_degree,
    output wire        o_occupied_indicator,
    // device operation
    output wire        o_fahrenheit,
    output wire        o_relay_on,
    output reg         o_override_flag,
    output wire        o_target_is_humidity,
    output wire [3:0]  o_target_step,
    output wire [15:0] o_upper_limit,
    output wire [15:0] o_target_clamped
);

    // ============================================================
    // state machine
    localparam [1:0] S_RX = 2'b01;
    localparam [1:0] S_TX = 2'b10;

    localparam [1:0] LCD_RESET = HAS_HUMIDITY ? `RST_LCD_T_RH
                                              : `RST_LCD_T_ONLY;
    localparam [15:0] LCD_MAX  = HAS_HUMIDITY ? `LCD_MODE_MAX_TRH
                                              : `LCD_MODE_MAX_T;

    // inclusive range test, used for the upper limit and the address check
    function in_range;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        begin
            in_range = (v >= lo) && (v <= hi);
        end
    endfunction

    reg [1:0]  state;
    reg [7:0]  rx_buf [0:7];
    reg [3:0]  rx_cnt;
    reg [15:0] rx_crc;
    reg [7:0]  tx_buf [0:7];
    reg [3:0]  tx_len;
    reg [3:0]  tx_idx;
    reg [15:0] tx_crc;

    // holding registers
    reg [15:0] upper_adjust_limit;
    reg [1:0]  lcd_content_select;
    reg        temp_scale_select;
    reg        lcd_temp_step;
    reg        occupied_symbol_on;
    reg        relay_drive;
    reg        target_quantity_select;
    reg        target_step_select;

    wire [15:0] rx_crc_next;
    wire [15:0] tx_crc_next;
    wire        alt_phase;
    integer     i;

    // ============================================================
    // crc on both directions
    crc16_byte_step #(
        .POLY (`CRC_POLY)
    ) u_rx_crc (
        .i_crc  (rx_crc),
        .i_byte (i_rx_byte),
        .o_crc  (rx_crc_next)
    );

    crc16_byte_step #(
        .POLY (`CRC_POLY)
    ) u_tx_crc (
        .i_crc  (tx_crc),
        .i_byte (o_tx_byte),
        .o_crc  (tx_crc_next)
    );

    // ============================================================
    // frame decode
    wire [7:0]  f_func  = rx_buf[1];
    wire [15:0] f_reg   = {rx_buf[2], rx_buf[3]};
    wire [15:0] f_value = {rx_buf[4], rx_buf[5]};

    // address zero is broadcast and never answered
    wire addr_match = (rx_buf[0] == i_slave_addr) &&
                      (i_slave_addr != 8'h00);
    // a good frame leaves a zero crc residue
    wire crc_ok     = (rx_crc == 16'h0000) &&
                      (rx_cnt >= `MIN_FRAME_BYTES);
    wire is_write   = (f_func == `FC_WRITE_SINGLE);
    wire addr_known = in_range(f_reg, `ADDR_UPPER_LIMIT,
                               `ADDR_TARGET_STEP);

    reg  value_ok;
    reg  [7:0] exc_code;

    // range per register, limits follow quantity and scale
    always @* begin
        value_ok = 1'b0;
        case (f_reg)
            `ADDR_UPPER_LIMIT: begin
                if (target_quantity_select) begin
                    value_ok = in_range(f_value, `LIMIT_RH_LO,
                                        `LIMIT_RH_HI);
                end else if (temp_scale_select) begin
                    value_ok = in_range(f_value, `LIMIT_F_LO,
                                        `LIMIT_F_HI);
                end else begin
                    value_ok = in_range(f_value, `LIMIT_C_LO,
                                        `LIMIT_C_HI);
                end
            end
            `ADDR_LCD_CONTENT: value_ok = (f_value <= LCD_MAX);
            `ADDR_OVR_CLEAR:   value_ok = (f_value == 16'h0000);
            default:           value_ok = (f_value <= `FLAG_VALUE_MAX);
        endcase
    end

    // priority: function, then address, then value
    always @* begin
        if (!is_write) begin
            exc_code = `EXC_ILLEGAL_FUNC;
        end else if (!addr_known) begin
            exc_code = `EXC_ILLEGAL_ADDR;
        end else if (!value_ok) begin
            exc_code = `EXC_ILLEGAL_DATA;
        end else begin
            exc_code = 8'h00;
        end
    end

    // short write frames are noise and get no answer
    wire frame_done = (state == S_RX) && i_rx_frame_end;
    wire respond    = frame_done && addr_match && crc_ok &&
                      (!is_write || (rx_cnt == `WRITE_FRAME_BYTES));
    wire do_write   = respond && (exc_code == 8'h00);

    // ============================================================
    // receive and transmit sequencing
    assign o_tx_valid = (state == S_TX);
    wire   tx_take    = o_tx_valid && i_tx_ready;
    wire [3:0] nxt_idx = tx_idx + 4'h1;

    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state     <= S_RX;
            rx_cnt    <= 4'h0;
            rx_crc    <= `CRC_SEED;
            tx_len    <= 4'h0;
            tx_idx    <= 4'h0;
            tx_crc    <= `CRC_SEED;
            o_tx_byte <= 8'h00;
        end else begin
            case (state)
                S_RX: begin
                    if (i_rx_frame_end) begin
                        rx_cnt <= 4'h0;
                        rx_crc <= `CRC_SEED;
                        if (respond) begin
                            state     <= S_TX;
                            tx_idx    <= 4'h0;
                            tx_crc    <= `CRC_SEED;
                            o_tx_byte <= rx_buf[0];
                            // echo the frame or send the short reply
                            tx_len <= (exc_code == 8'h00)
                                      ? `WRITE_FRAME_BYTES
                                      : `EXC_FRAME_BYTES;
                        end
                    end else if (i_rx_valid) begin
                        rx_crc <= rx_crc_next;
                        // overlong frames saturate and fail length
                        if (rx_cnt != 4'h9) begin
                            rx_cnt <= rx_cnt + 4'h1;
                        end
                    end
                end
                S_TX: begin
                    if (tx_take) begin
                        tx_idx <= nxt_idx;
                        if (tx_idx < tx_len - 4'h2) begin
                            tx_crc <= tx_crc_next;
                        end
                        // crc bytes go out low byte first
                        if (nxt_idx == tx_len) begin
                            state <= S_RX;
                        end else if (nxt_idx == tx_len - 4'h2) begin
                            o_tx_byte <= tx_crc_next[7:0];
                        end else if (nxt_idx == tx_len - 4'h1) begin
                            o_tx_byte <= tx_crc[15:8];
                        end else begin
                            o_tx_byte <= tx_buf[nxt_idx[2:0]];
                        end
                    end
                end
                default: state <= S_RX;
            endcase
        end
    end

    // frame capture; bytes beyond eight are dropped
    always @(posedge i_core_clk) begin
        if ((state == S_RX) && i_rx_valid && !i_rx_frame_end &&
            (rx_cnt < `WRITE_FRAME_BYTES)) begin
            rx_buf[rx_cnt[2:0]] <= i_rx_byte;
        end
    end

    // reply image: the frame itself, or address, flagged code, cause
    always @(posedge i_core_clk) begin
        if (respond) begin
            for (i = 0; i < 8; i = i + 1) begin
                tx_buf[i] <= rx_buf[i];
            end
            if (exc_code != 8'h00) begin
                tx_buf[1] <= f_func | `FC_EXCEPTION_FLAG;
                tx_buf[2] <= exc_code;
            end
        end
    end

    // ============================================================
    // holding register writes, only after a clean decode
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            upper_adjust_limit     <= `RST_UPPER_LIMIT;
            lcd_content_select     <= LCD_RESET;
            temp_scale_select      <= 1'b0;
            lcd_temp_step          <= 1'b0;
            occupied_symbol_on     <= 1'b0;
            relay_drive            <= 1'b0;
            target_quantity_select <= 1'b0;
            target_step_select     <= 1'b0;
        end else if (do_write) begin
            case (f_reg)
                `ADDR_UPPER_LIMIT:
                    upper_adjust_limit <= f_value;
                `ADDR_LCD_CONTENT:
                    lcd_content_select <= f_value[1:0];
                `ADDR_TEMP_SCALE:
                    temp_scale_select <= f_value[0];
                `ADDR_LCD_STEP:
                    lcd_temp_step <= f_value[0];
                `ADDR_OCCUPIED:
                    occupied_symbol_on <= f_value[0];
                `ADDR_RELAY:
                    relay_drive <= f_value[0];
                `ADDR_TARGET_QTY:
                    target_quantity_select <= f_value[0];
                `ADDR_TARGET_STEP:
                    target_step_select <= f_value[0];
                default: ;
            endcase
        end
    end

    // ============================================================
    // override flag: a press beats a same-cycle clear
    wire ovr_clear = do_write && (f_reg == `ADDR_OVR_CLEAR);

    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_override_flag <= 1'b0;
        end else if (HAS_OVERRIDE && i_override_pressed) begin
            o_override_flag <= 1'b1;
        end else if (HAS_OVERRIDE && ovr_clear) begin
            o_override_flag <= 1'b0;
        end
    end

    // ============================================================
    // display selection
    wire alt_mode = HAS_HUMIDITY &&
                    (lcd_content_select == `LCD_ALTERNATE);

    alt_toggle_timer #(
        .PERIOD_CYCLES (ALT_PERIOD_CYCLES)
    ) u_alt_timer (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_enable   (alt_mode),
        .o_phase    (alt_phase)
    );

    // humidity modes cannot show on a device without the sensor
    assign o_lcd_show_temp     = (lcd_content_select == `LCD_TEMP) ||
                                 (alt_mode && !alt_phase);
    assign o_lcd_show_humidity = HAS_HUMIDITY &&
                                 ((lcd_content_select == `LCD_HUMID) ||
                                  (alt_mode && alt_phase));
    assign o_backlight_on      = (lcd_content_select != `LCD_BLANK) ||
                                 i_menu_active;
    assign o_lcd_half_degree   = lcd_temp_step;
    assign o_occupied_indicator = occupied_symbol_on;
    assign o_fahrenheit        = temp_scale_select;
    assign o_relay_on          = HAS_RELAY && relay_drive;

    // ============================================================
    // setpoint handling, inert without the setpoint option
    wire sp_on = (HAS_SETPOINT != 0);

    assign o_target_is_humidity = sp_on && target_quantity_select;
    assign o_upper_limit = sp_on ? upper_adjust_limit : 16'h0000;

    // step in tenths of a degree, or whole percent for humidity
    assign o_target_step = !sp_on ? 4'h0 :
                           target_quantity_select ? 4'h1 :
                           target_step_select ? 4'h5 : 4'ha;

    // clamp covers panel stepping and network writes
    assign o_target_clamped =
        (sp_on && (i_target_value > upper_adjust_limit))
        ? upper_adjust_limit : i_target_value;

endmodule // sensor_config_holding_regs

// File: sim/fieldbus_master_model.sv
// Purpose: field-bus master model for the holding-register bank
// Assumes: bytes already deframed, one frame at a time
// Notes:   ready stalls at random only while slow is set
`timescale 1ns/100ps
// ==========
// master model
module fieldbus_master_model (
    input  wire       i_core_clk,
    output reg  [7:0] o_byte      = 8'h00,
    output reg        o_valid     = 1'b0,
    output reg        o_frame_end = 1'b0,
    output reg        o_ready     = 1'b1
);
    integer    seed = 32'he8a0;
    reg        slow = 1'b0;
    // reflected crc, shared by frames and expected replies
    function [15:0] crc(input [63:0] d, input integer n);
        integer i, k;
        begin
            crc = 16'hffff;
            for (i = 0; i < n; i = i + 1) begin
                crc = crc ^ d[63-8*i -: 8];
                for (k = 0; k < 8; k = k + 1)
                    crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
            end
        end
    endfunction
    function [7:0] rnd();
        rnd = $random(seed);
    endfunction
    // n frame bytes, crc low first; flip spoils the crc
    task send(input [47:0] f, input integer n, input [15:0] flip);
        reg [15:0] c;
        reg [63:0] d;
        integer    i;
        begin
            c = crc({f, 16'h0}, 6) ^ flip;
            d = {f, c[7:0], c[15:8]};
            for (i = 0; i < n; i = i + 1) begin
                @(posedge i_core_clk);
                o_byte  <= d[63-8*i -: 8];
                o_valid <= 1'b1;
            end
            @(posedge i_core_clk);
            o_valid     <= 1'b0;
            o_byte      <= ~o_byte;
            o_frame_end <= 1'b1;
            @(posedge i_core_clk);
            o_frame_end <= 1'b0;
        end
    endtask
    // a slow master takes reply bytes at random cycles
    always @(posedge i_core_clk) begin
        o_ready <= !slow || ($random(seed) & 1);
    end
endmodule // fieldbus_master_model

// File: sim/sensor_config_checker.sv
// Purpose: port assertions for the holding-register bank
// Assumes: all options fitted, one clock domain
// Notes:   bound to the bank, sees only its ports
`timescale 1ns/100ps
// ==========
// checker
module sensor_config_checker (
    input logic        i_core_clk,
    input logic        i_sys_rst,
    input logic        i_rx_frame_end,
    input logic [7:0]  o_tx_byte,
    input logic        o_tx_valid,
    input logic        i_tx_ready,
    input logic        i_override_pressed,
    input logic        i_menu_active,
    input logic [15:0] i_target_value,
    input logic        o_lcd_show_temp,
    input logic        o_lcd_show_humidity,
    input logic        o_backlight_on,
    input logic        o_fahrenheit,
    input logic        o_relay_on,
    input logic        o_override_flag,
    input logic        o_target_is_humidity,
    input logic [3:0]  o_target_step,
    input logic [15:0] o_upper_limit,
    input logic [15:0] o_target_clamped
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // byte not yet taken, still offered next cycle
    sequence s_stalled;
        o_tx_valid && !i_tx_ready ##1 o_tx_valid;
    endsequence
    // a setting moved
    sequence s_cfg_moved;
        $changed({o_upper_limit, o_fahrenheit, o_relay_on});
    endsequence
    a_reply_after_end: assert property (
        $rose(o_tx_valid) |-> $past(i_rx_frame_end))
        else $error("reply without frame end");
    a_stalled_byte_held: assert property (
        s_stalled |-> $stable(o_tx_byte))
        else $error("stalled byte changed");
    a_target_clamped: assert property (
        o_target_clamped == ((i_target_value > o_upper_limit) ?
                             o_upper_limit : i_target_value))
        else $error("target not clamped");
    a_blank_no_light: assert property (
        !o_lcd_show_temp && !o_lcd_show_humidity && !i_menu_active
        |-> !o_backlight_on)
        else $error("blank but lit");
    a_menu_lights: assert property (
        i_menu_active |-> o_backlight_on)
        else $error("menu but dark");
    a_press_sets_flag: assert property (
        i_override_pressed |=> o_override_flag)
        else $error("press lost");
    a_clear_needs_frame: assert property (
        $fell(o_override_flag) |-> $past(i_rx_frame_end))
        else $error("clear without frame");
    a_rh_step_one: assert property (
        o_target_is_humidity |-> o_target_step == 4'h1)
        else $error("rh step not one");
    a_cfg_by_frame: assert property (
        s_cfg_moved |-> $past(i_rx_frame_end))
        else $error("setting moved without frame");
endmodule // sensor_config_checker

bind sensor_config_holding_regs sensor_config_checker
    sensor_config_checker_inst (.*);

// File: sim/test_sensor_config_holding_regs.sv
// Purpose: self-checking bench for the sensor holding-register bank
// Assumes: all options fitted, alternate period of 20 cycles
// Notes:   expected reply bytes queue up before each frame
`timescale 1ns/100ps
module test_sensor_config_holding_regs;
    localparam [7:0] SA = 8'h2c;
    // ==========
    // signals
    reg         i_core_clk         = 1'b0;
    reg         i_sys_rst          = 1'b1;
    reg  [7:0]  i_slave_addr       = SA;
    reg         i_override_pressed = 1'b0;
    reg         i_menu_active      = 1'b0;
    reg  [15:0] i_target_value     = 16'h0000;
    wire [7:0]  i_rx_byte, o_tx_byte;
    wire        i_rx_valid, i_rx_frame_end, i_tx_ready, o_tx_valid;
    wire        o_lcd_show_temp, o_lcd_show_humidity, o_backlight_on;
    wire        o_lcd_half_degree, o_occupied_indicator, o_fahrenheit;
    wire        o_relay_on, o_override_flag, o_target_is_humidity;
    wire [3:0]  o_target_step;
    wire [15:0] o_upper_limit, o_target_clamped;
    wire [2:0]  lcd = {o_lcd_show_temp, o_lcd_show_humidity, o_backlight_on};
    wire [5:0]  obits = {o_target_step == 4'h5, o_target_is_humidity,
                         o_relay_on, o_occupied_indicator,
                         o_lcd_half_degree, o_fahrenheit};
    reg  [7:0]  exp_q[$];
    reg  [31:0] lt [0:13];
    reg  [63:0] rp;
    reg  [15:0] c, el;
    integer     mismatches = 0, comparisons = 0, i, k, n;

    sensor_config_holding_regs #(.ALT_PERIOD_CYCLES(20))
        sensor_config_holding_regs_inst (.*);
    fieldbus_master_model m_inst (.i_core_clk(i_core_clk),
        .o_byte(i_rx_byte), .o_valid(i_rx_valid),
        .o_frame_end(i_rx_frame_end), .o_ready(i_tx_ready));

    initial forever #4 i_core_clk = ~i_core_clk;
    // ==========
    // compare, verdict and transfer tasks
    task chk(input [8*12:1] nm, input [15:0] e, input [15:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("BAD %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task results;
        begin
            $display("comparisons %0d mismatches %0d", comparisons,
                     mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // code 0 echo, 1..3 exception, ff no reply expected
    task xfer(input [47:0] f, input integer n, input [15:0] flip,
              input [7:0] code);
        begin
            rp = {f, 16'h0};
            k = code ? 3 : 6;
            if (code)
                rp[55:40] = {f[39:32] | 8'h80, code};
            c = m_inst.crc(rp, k);
            rp[63-8*k -: 16] = {c[7:0], c[15:8]};
            for (i = 0; i < k + 2 && code != 8'hff; i = i + 1)
                exp_q.push_back(rp[63-8*i -: 8]);
            m_inst.send(f, n, flip);
            for (i = 0; i < 200 && (exp_q.size() != 0 || o_tx_valid); i++)
                @(posedge i_core_clk);
            if (i == 200) begin
                mismatches = mismatches + 1;
                results;
            end
            repeat (12) @(posedge i_core_clk);
        end
    endtask
    task wr(input [15:0] a, input [15:0] v, input [7:0] code);
        xfer({SA, 8'h06, a, v}, 8, 16'h0, code);
    endtask
    // each reply byte taken is matched to the oldest note
    always @(posedge i_core_clk)
        if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1)
            chk("reply byte", exp_q.size() ? exp_q.pop_front() : 8'hxx,
                o_tx_byte);
    // ==========
    // main sequence
    initial begin
        lt = '{32'h0900c703, 32'h0900c800, 32'h09012d03, 32'h0b000100,
               32'h09012c03, 32'h0902a703, 32'h09035c00, 32'h09035d03,
               32'h0b000000, 32'h10000100, 32'h09001d03, 32'h09005103,
               32'h09001e00, 32'h09005000};
        repeat (8) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_core_clk);
        chk("limit", 16'h012c, o_upper_limit);
        chk("lcd", 3'b101, lcd);
        chk("bits", 0, {obits, o_override_flag});
        $display("test reset done");
        for (n = 0; n < 6; n = n + 1) begin
            el = (n < 3) ? 16'hb + n : 16'hc + n;
            wr(el, 16'h1, 8'h0);
            chk("bit on", 1, obits[n]);
            wr(el, 16'h2, 8'h3);
            chk("bit kept", 1, obits[n]);
            wr(el, 16'h0, 8'h0);
            chk("bit off", 0, obits[n]);
        end
        chk("step", 16'ha, o_target_step);
        $display("test flags done");
        el = 16'h012c;
        for (n = 0; n < 14; n = n + 1) begin
            wr(lt[n][31:24], lt[n][23:8], lt[n][7:0]);
            if (lt[n][31:24] == 8'h09 && lt[n][7:0] == 8'h00)
                el = lt[n][23:8];
            chk("limit", el, o_upper_limit);
        end
        wr(16'h11, 16'h1, 8'h0);
        chk("rh step", 16'h1, o_target_step);
        for (n = 0; n < 4; n = n + 1) begin
            i_target_value <= {8'h00, m_inst.rnd()};
            repeat (2) @(posedge i_core_clk);
            el = (i_target_value > 16'h50) ? 16'h50 : i_target_value;
            chk("clamped", el, o_target_clamped);
        end
        wr(16'h11, 16'h0, 8'h0);
        wr(16'h10, 16'h0, 8'h0);
        $display("test limit done");
        m_inst.slow = 1'b1;
        wr(16'ha, 16'h0, 8'h0);
        chk("lcd", 3'b000, lcd);
        i_menu_active <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        chk("menu light", 1, o_backlight_on);
        i_menu_active <= 1'b0;
        wr(16'ha, 16'h1, 8'h0);
        chk("lcd", 3'b101, lcd);
        wr(16'ha, 16'h2, 8'h0);
        chk("lcd", 3'b011, lcd);
        wr(16'ha, 16'h4, 8'h3);
        chk("lcd", 3'b011, lcd);
        wr(16'ha, 16'h3, 8'h0);
        for (i = 0; i < 40 && !o_lcd_show_humidity; i++)
            @(posedge i_core_clk);
        for (i = 0; i < 40 && o_lcd_show_humidity; i++)
            @(posedge i_core_clk);
        for (n = 0; n < 40 && !o_lcd_show_humidity; n++)
            @(posedge i_core_clk);
        chk("alt period", 16'h14, n);
        $display("test display done");
        i_override_pressed <= 1'b1;
        @(posedge i_core_clk);
        i_override_pressed <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        chk("flag set", 1, o_override_flag);
        wr(16'he, 16'h1, 8'h3);
        chk("flag kept", 1, o_override_flag);
        wr(16'he, 16'h0, 8'h0);
        chk("flag clear", 0, o_override_flag);
        $display("test override done");
        xfer({8'h2d, 8'h06, 16'h000d, 16'h0001}, 8, 16'h0, 8'hff);
        xfer({SA, 8'h06, 16'h000d, 16'h0001}, 8, 16'h0100, 8'hff);
        xfer({SA, 8'h06, 16'h000d, 16'h0001}, 4, 16'h0, 8'hff);
        chk("occupied", 0, o_occupied_indicator);
        xfer({SA, 8'h03, 16'h000d, 16'h0001}, 8, 16'h0, 8'h01);
        wr(16'h0008, 16'h0, 8'h2);
        wr(16'h0012, 16'h0, 8'h2);
        $display("test refusals done");
        results;
    end
endmodule // test_sensor_config_holding_regs
